/* uss_shift_reg.sv */
`timescale 1ns/1ps
// Operation
// - Eight storage stages with selectable next value
// - Low clear forces all stages zero immediately
// - Apart from clear, state changes only on shift clock rise
// - Both selects high loads bus into stages
// - Shift right: serial into stage 0
// - Shift left: serial into stage 7
// - Both selects low holds all stages
// - Either enable high releases the bus
// - Operations continue while bus released
// - Load mode also releases the bus
// - Enabled drivers show stages; bus feeds loads
// - Stage 0 and 7 on dedicated outputs
module uss_shift_reg #(
  parameter int WIDTH = 8,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk,
  input wire logic rstn,
  // Device pins
  input wire logic shift_clock,
  input wire logic right_serial_in,
  input wire logic left_serial_in,
  input wire logic mode_sel_hi,
  input wire logic mode_sel_lo,
  input wire logic clear_n,
  input wire logic out_en_a_n,
  input wire logic out_en_b_n,
  input wire logic [WIDTH-1:0] parBusIn,
  output logic [WIDTH-1:0] parBusOut,
  output logic parBusOe_n,
  output logic first_stage_out,
  output logic last_stage_out,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uss_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;

  uss_pkg::uss_pins_s pinsRaw;
  uss_pkg::uss_pins_s pins;
  uss_pkg::uss_mode_e mode;
  uss_pkg::uss_snap_s snapIn;
  uss_pkg::uss_snap_s snapOut;
  logic [WIDTH-1:0] stage_q;
  logic [WIDTH-1:0] stage_d;
  logic clkPrev_q;
  logic clkRise;
  logic clrN;
  logic updated_q;
  logic capture_q;
  logic overflow_q;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic [CNT_W-1:0] fifoCount;
  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic [31:0] rdData;
  logic addrHit;

  initial begin
    if (WIDTH != uss_pkg::STAGES) $error("uss_shift_reg: WIDTH must equal the stage count");
    if (FIFO_DEPTH < 2) $error("uss_shift_reg: FIFO_DEPTH too small");
  end

  // Every pin except the clear passes the three-flop synchroniser
  assign pinsRaw = '{
    shiftClock: shift_clock,
    rightSerialIn: right_serial_in,
    leftSerialIn: left_serial_in,
    modeSelHi: mode_sel_hi,
    modeSelLo: mode_sel_lo,
    outEnA_n: out_en_a_n,
    outEnB_n: out_en_b_n,
    parBus: parBusIn
  };

  uss_pin_sync #(
    .WIDTH(uss_pkg::PINS_W),
    .RST_VAL(uss_pkg::PINS_RST)
  ) pinSync (
    .clk(clk),
    .rstn(rstn),
    .pinIn(pinsRaw),
    .pinStable(pins)
  );

  // Data and selects travel through the same chain, so they stay aligned to the clock edge
  assign mode = uss_pkg::uss_mode_e'({pins.modeSelHi, pins.modeSelLo});

  // Edge detector on the filtered shift clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkPrev_q <= 1'b0;
    end else begin
      clkPrev_q <= pins.shiftClock;
    end
  end

  assign clkRise = pins.shiftClock && !clkPrev_q;

  // Next-value logic of the inter-stage network
  always_comb begin
    stage_d = stage_q;
    case (mode)
      uss_pkg::MODE_LOAD: begin
        stage_d = pins.parBus;
      end
      uss_pkg::MODE_RIGHT: begin
        stage_d = {stage_q[WIDTH-2:0], pins.rightSerialIn};
      end
      uss_pkg::MODE_LEFT: begin
        stage_d = {pins.leftSerialIn, stage_q[WIDTH-1:1]};
      end
      default: begin
        stage_d = stage_q;
      end
    endcase
  end

  // Raw clear pin acts asynchronously, so it bypasses the synchroniser
  assign clrN = rstn && clear_n;

  // Stage flops; the output enables play no part here
  always_ff @(posedge clk or negedge clrN) begin
    if (!clrN) begin
      stage_q <= uss_pkg::STAGE_RST;
    end else if (clkRise) begin
      stage_q <= stage_d;
    end
  end

  // Bus drivers released by either enable or by load mode
  assign parBusOe_n = pins.outEnA_n || pins.outEnB_n
    || (mode == uss_pkg::MODE_LOAD);
  assign parBusOut = stage_q;

  // Cascade outputs come straight from the end stages
  assign first_stage_out = stage_q[0];
  assign last_stage_out = stage_q[WIDTH-1];

  // Marks a clocked update one cycle later so the snapshot holds the new value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      updated_q <= 1'b0;
    end else begin
      updated_q <= clkRise && (mode != uss_pkg::MODE_HOLD);
    end
  end

  assign snapIn = '{mode: mode, stages: stage_q};

  // Capture FIFO; a full FIFO refuses snapshots and raises overflow
  uss_fifo #(
    .WIDTH(uss_pkg::SNAP_W),
    .DEPTH(FIFO_DEPTH)
  ) snapFifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(updated_q && capture_q),
    .inReady(fifoInReady),
    .inData(snapIn),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(snapOut),
    .count(fifoCount)
  );

  // Zero-wait-state APB slave
  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite;
  assign apbRead = apbAccess && !pwrite;
  assign pready = 1'b1;
  assign fifoPop = apbRead && (paddr == uss_pkg::DATA_OFFS) && fifoOutValid;

  // Address decode and read mux
  always_comb begin
    rdData = 32'h00000000;
    addrHit = 1'b1;
    if (paddr == uss_pkg::CTRL_OFFS) begin
      rdData[uss_pkg::CTRL_CAPTURE_BIT] = capture_q;
    end else if (paddr == uss_pkg::STATUS_OFFS) begin
      rdData[uss_pkg::STAT_STAGE_LSB +: WIDTH] = stage_q;
      rdData[uss_pkg::STAT_EMPTY_BIT] = !fifoOutValid;
      rdData[uss_pkg::STAT_FULL_BIT] = !fifoInReady;
      rdData[uss_pkg::STAT_OVF_BIT] = overflow_q;
      rdData[uss_pkg::STAT_COUNT_LSB +: CNT_W] = fifoCount;
    end else if (paddr == uss_pkg::DATA_OFFS) begin
      rdData[uss_pkg::DATA_STAGE_LSB +: WIDTH] = snapOut.stages;
      rdData[uss_pkg::DATA_MODE_LSB +: 2] = snapOut.mode;
      rdData[uss_pkg::DATA_VALID_BIT] = fifoOutValid;
    end else begin
      addrHit = 1'b0;
    end
  end

  assign pslverr = apbAccess && !addrHit;

  // Read data registered at the access edge would be one cycle late, so it is muxed live
  assign prdata = apbRead ? rdData : 32'h00000000;

  // Control register: capture enable steers the FIFO push
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capture_q <= uss_pkg::CTRL_CAPTURE_RST;
    end else if (apbWrite && paddr == uss_pkg::CTRL_OFFS) begin
      capture_q <= pwdata[uss_pkg::CTRL_CAPTURE_BIT];
    end
  end

  // Overflow sticky bit; a new drop wins over a write-one clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overflow_q <= 1'b0;
    end else if (updated_q && capture_q && !fifoInReady) begin
      overflow_q <= 1'b1;
    end else if (apbWrite && paddr == uss_pkg::STATUS_OFFS && pwdata[uss_pkg::STAT_OVF_BIT]) begin
      overflow_q <= 1'b0;
    end
  end
endmodule // uss_shift_reg

/* uss_pkg.sv */
package uss_pkg;
  // Register geometry
  localparam int STAGES = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_W = 12;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFFS = 12'h000;
  localparam logic [11:0] STATUS_OFFS = 12'h004;
  localparam logic [11:0] DATA_OFFS = 12'h008;

  // Control register fields
  localparam int CTRL_CAPTURE_BIT = 0;
  localparam logic CTRL_CAPTURE_RST = 1'b0;

  // Status register fields
  localparam int STAT_STAGE_LSB = 0;
  localparam int STAT_EMPTY_BIT = 8;
  localparam int STAT_FULL_BIT = 9;
  localparam int STAT_OVF_BIT = 10;
  localparam int STAT_COUNT_LSB = 16;

  // Data register fields
  localparam int DATA_STAGE_LSB = 0;
  localparam int DATA_MODE_LSB = 8;
  localparam int DATA_VALID_BIT = 12;

  // Pin synchroniser depth and stage reset value
  localparam int SYNC_STAGES = 3;
  localparam logic [7:0] STAGE_RST = 8'h00;

  // Mode encoding: {mode_sel_hi, mode_sel_lo}
  typedef enum logic [1:0] {
    MODE_HOLD = 2'b00,
    MODE_RIGHT = 2'b01,
    MODE_LEFT = 2'b10,
    MODE_LOAD = 2'b11
  } uss_mode_e;

  // Synchronised pin group
  typedef struct packed {
    logic shiftClock;
    logic rightSerialIn;
    logic leftSerialIn;
    logic modeSelHi;
    logic modeSelLo;
    logic outEnA_n;
    logic outEnB_n;
    logic [7:0] parBus;
  } uss_pins_s;

  localparam int PINS_W = $bits(uss_pins_s);
  localparam logic [PINS_W-1:0] PINS_RST = {1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00};

  // Snapshot pushed into the capture FIFO after each update while capture is enabled
  typedef struct packed {
    uss_mode_e mode;
    logic [7:0] stages;
  } uss_snap_s;

  localparam int SNAP_W = $bits(uss_snap_s);
endpackage

/* uss_pin_sync.sv */
`timescale 1ns/1ps
module uss_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinStable
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] sync3_q;

  initial begin
    if (WIDTH < 1) $error("uss_pin_sync: WIDTH must be at least 1");
  end

  // Three-flop chain; the first flop feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RST_VAL;
      sync2_q <= RST_VAL;
      sync3_q <= RST_VAL;
    end else begin
      meta_q <= pinIn;
      sync2_q <= meta_q;
      sync3_q <= sync2_q;
    end
  end

  // A bit changes only once the last two stages agree, filtering one-cycle glitches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinStable <= RST_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pinStable[i] <= sync3_q[i];
        end
      end
    end
  end
endmodule // uss_pin_sync

/* uss_fifo.sv */
`timescale 1ns/1ps
module uss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] count
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic [PTR_W:0] count_q;
  logic doPush;
  logic doPop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("uss_fifo: DEPTH must be a power of two");
    if (WIDTH < 1) $error("uss_fifo: WIDTH must be at least 1");
  end

  // Handshakes are combinational from the fill level
  assign inReady = (count_q != (PTR_W + 1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  assign outData = mem_q[rdPtr_q];
  assign count = count_q;

  // Storage; no reset needed since empty hides stale words
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // Pointers wrap naturally because depth is a power of two
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPush) wrPtr_q <= wrPtr_q + 1'b1;
      if (doPop) rdPtr_q <= rdPtr_q + 1'b1;
      if (doPush && !doPop) count_q <= count_q + 1'b1;
      else if (doPop && !doPush) count_q <= count_q - 1'b1;
    end
  end
endmodule // uss_fifo

/* uss_shift_reg_properties.sv */
`timescale 1ns/1ps
module uss_shift_reg_properties #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic shift_clock,
  input wire logic right_serial_in,
  input wire logic left_serial_in,
  input wire logic mode_sel_hi,
  input wire logic mode_sel_lo,
  input wire logic clear_n,
  input wire logic out_en_a_n,
  input wire logic out_en_b_n,
  input wire logic [WIDTH-1:0] parBusIn,
  input wire logic [WIDTH-1:0] parBusOut,
  input wire logic parBusOe_n,
  input wire logic first_stage_out,
  input wire logic last_stage_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Pin rises land within seven edges, so checks look seven edges on
  load_result_a: assert property ($rose(shift_clock) && clear_n && mode_sel_hi && mode_sel_lo
    |-> ##7 parBusOut == $past(parBusIn, 7)) else $error("load result wrong");
  right_result_a: assert property ($rose(shift_clock) && clear_n && !mode_sel_hi && mode_sel_lo
    |-> ##7 parBusOut == {$past(parBusOut[WIDTH-2:0], 7), $past(right_serial_in, 7)})
    else $error("right shift wrong");
  left_result_a: assert property ($rose(shift_clock) && clear_n && mode_sel_hi && !mode_sel_lo
    |-> ##7 parBusOut == {$past(left_serial_in, 7), $past(parBusOut[WIDTH-1:1], 7)})
    else $error("left shift wrong");
  clear_zero_a: assert property (!clear_n |-> parBusOut == '0)
    else $error("stages not cleared");
  hold_stable_a: assert property ((!mode_sel_hi && !mode_sel_lo && clear_n)[*8]
    |=> !clear_n || $stable(parBusOut)) else $error("hold changed stages");
  quiet_clock_a: assert property (($stable(shift_clock) && clear_n)[*8]
    |=> !clear_n || $stable(parBusOut)) else $error("change without clock");
  bus_release_a: assert property ((out_en_a_n || out_en_b_n)[*6] |-> parBusOe_n)
    else $error("bus driven while disabled");
  load_release_a: assert property ((mode_sel_hi && mode_sel_lo)[*6] |-> parBusOe_n)
    else $error("bus driven in load");
  bus_drive_a: assert property ((!out_en_a_n && !out_en_b_n && !(mode_sel_hi && mode_sel_lo))[*6]
    |-> !parBusOe_n) else $error("bus not driven");
  stage_taps_a: assert property (first_stage_out == parBusOut[0]
    && last_stage_out == parBusOut[WIDTH-1]) else $error("tap outputs wrong");
  cover property ($rose(shift_clock) && mode_sel_hi && mode_sel_lo);
  cover property ($rose(shift_clock) && !mode_sel_hi && mode_sel_lo);
  cover property ($fell(clear_n));
endmodule // uss_shift_reg_properties

bind uss_shift_reg uss_shift_reg_properties #(.WIDTH(WIDTH)) u_uss_shift_reg_properties (
  .clk(clk), .rstn(rstn), .shift_clock(shift_clock), .right_serial_in(right_serial_in),
  .left_serial_in(left_serial_in), .mode_sel_hi(mode_sel_hi), .mode_sel_lo(mode_sel_lo),
  .clear_n(clear_n), .out_en_a_n(out_en_a_n), .out_en_b_n(out_en_b_n), .parBusIn(parBusIn),
  .parBusOut(parBusOut), .parBusOe_n(parBusOe_n), .first_stage_out(first_stage_out),
  .last_stage_out(last_stage_out));

/* uss_bus_partner.sv */
`timescale 1ns/1ps
module uss_bus_partner (
  input wire logic clk,
  input wire logic [7:0] parBusOut,
  input wire logic parBusOe_n,
  input wire logic drvEn,
  input wire logic [7:0] drvData,
  output logic [7:0] busLevel
);
  logic [7:0] lastQ = 8'h00;
  // Resolve the shared bus; contention shows as unknown
  always_comb begin
    if (!parBusOe_n && drvEn) busLevel = 8'hXX;
    else if (!parBusOe_n) busLevel = parBusOut;
    else if (drvEn) busLevel = drvData;
    else busLevel = ~lastQ; // No pull-up, so a floating bus keeps toggling
  end
  // Remember the level for the floating case
  always_ff @(posedge clk) lastQ <= busLevel;
endmodule // uss_bus_partner

/* tb_universal_shift_storage_reg8.sv */
`timescale 1ns/1ps
module tb_universal_shift_storage_reg8;
  typedef struct packed {logic [1:0] m; logic r; logic l; logic [7:0] d; logic [7:0] e;} uss_row_s;
  logic clk = 0, rstn = 0, shiftClock = 0, rsi = 0, lsi = 0, selHi = 0, selLo = 0, clearN = 1;
  logic enA_n = 0, enB_n = 0, drvEn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] drvData = 8'h00, parBusOut, busLevel, exp;
  logic [7:0] snaps [33];
  logic parBusOe_n, firstOut, lastOut, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int n_errors = 0, n_tests = 0;
  uss_row_s rows [7] = '{'{2'b11, 0, 0, 8'hA5, 8'hA5}, '{2'b01, 1, 0, 8'h00, 8'h4B},
    '{2'b10, 0, 1, 8'h00, 8'hA5}, '{2'b00, 1, 1, 8'h00, 8'hA5}, '{2'b11, 0, 0, 8'h3C, 8'h3C},
    '{2'b01, 0, 1, 8'h00, 8'h78}, '{2'b10, 1, 0, 8'h00, 8'h3C}};
  always #5 clk = ~clk;
  uss_shift_reg u_uss_shift_reg (.clk(clk), .rstn(rstn), .shift_clock(shiftClock),
    .right_serial_in(rsi), .left_serial_in(lsi), .mode_sel_hi(selHi), .mode_sel_lo(selLo),
    .clear_n(clearN), .out_en_a_n(enA_n), .out_en_b_n(enB_n), .parBusIn(busLevel),
    .parBusOut(parBusOut), .parBusOe_n(parBusOe_n), .first_stage_out(firstOut),
    .last_stage_out(lastOut), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  uss_bus_partner u_uss_bus_partner (.clk(clk), .parBusOut(parBusOut), .parBusOe_n(parBusOe_n),
    .drvEn(drvEn), .drvData(drvData), .busLevel(busLevel));
  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // One APB transfer; the wait on pready is bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      chk("pready", 1, 0);
      stop_test();
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Idle cycle so a following call never re-raises psel in the same step
    @(posedge clk);
  endtask
  // Inputs settle well before the clock rise and stay put after it
  task automatic op(input logic [1:0] m, input logic r, input logic l, input logic [7:0] d);
    selHi <= m[1]; selLo <= m[0]; rsi <= r; lsi <= l;
    repeat (6) @(posedge clk);
    drvEn <= (m == 2'b11); drvData <= d;
    repeat (6) @(posedge clk);
    shiftClock <= 1'b1;
    repeat (8) @(posedge clk);
    shiftClock <= 1'b0;
    repeat (8) @(posedge clk);
    drvEn <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    chk("rst stages", 0, parBusOut);
    chk("rst oe", 1, parBusOe_n);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    foreach (rows[i]) begin
      op(rows[i].m, rows[i].r, rows[i].l, rows[i].d);
      chk("stages", rows[i].e, parBusOut);
      chk("taps", {rows[i].e[7], rows[i].e[0]}, {lastOut, firstOut});
      if (rows[i].m == 2'b11) chk("load oe", 1, parBusOe_n);
      else chk("bus", rows[i].e, busLevel);
      apb(0, uss_pkg::STATUS_OFFS, 0);
      chk("status", rows[i].e, rd[7:0]);
    end
    enA_n <= 1'b1;
    op(2'b01, 1, 0, 8'h00);
    chk("released shift", 8'h79, parBusOut);
    chk("oe a", 1, parBusOe_n);
    enA_n <= 1'b0; enB_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("oe b", 1, parBusOe_n);
    enB_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("bus on", 8'h79, busLevel);
    clearN <= 1'b0;
    #2 chk("clear", 0, {firstOut, lastOut, parBusOut});
    @(posedge clk);
    clearN <= 1'b1;
    apb(1, uss_pkg::CTRL_OFFS, 32'h1);
    apb(0, uss_pkg::CTRL_OFFS, 0);
    chk("ctrl", 1, rd[0]);
    exp = 8'h00;
    // One more snapshot than the buffer holds, so the last is dropped
    for (int i = 0; i < 33; i++) begin
      op(2'b01, i[0], 0, 8'h00);
      exp = {exp[6:0], i[0]};
      snaps[i] = exp;
    end
    apb(0, uss_pkg::STATUS_OFFS, 0);
    chk("full", {6'h20, 5'h0, 3'b110}, {rd[21:16], rd[15:11], rd[10:8]});
    apb(1, uss_pkg::STATUS_OFFS, 32'h400);
    apb(0, uss_pkg::STATUS_OFFS, 0);
    chk("ovf clear", 0, rd[10]);
    for (int i = 0; i < 32; i++) begin
      apb(0, uss_pkg::DATA_OFFS, 0);
      chk("snap", {1'b1, 2'b01, snaps[i]}, {rd[12], rd[9:8], rd[7:0]});
    end
    apb(0, uss_pkg::STATUS_OFFS, 0);
    chk("empty", {6'h00, 1'b1}, {rd[21:16], rd[8]});
    apb(0, 12'h010, 0);
    chk("unmapped", {1'b1, 32'h0}, {err, rd});
    stop_test();
  end
endmodule // tb_universal_shift_storage_reg8
